/* File: rtl/lcar_pkg.sv */
// Package of constants and types for the layer attribute and scroll register block.
package lcar_pkg;
   // ************************************************************
   // Register offsets.
   // ************************************************************
   localparam logic [15:0] LCAR_OFF_CONFIG = 16'h8000;
   localparam logic [15:0] LCAR_OFF_DISP_ENABLE = 16'h8009;
   localparam logic [15:0] LCAR_OFF_ATTR = 16'h800A;
   localparam logic [15:0] LCAR_OFF_B1_LOW = 16'h800B;
   localparam logic [15:0] LCAR_OFF_B1_HIGH = 16'h800C;
   localparam logic [15:0] LCAR_OFF_B1_LINES = 16'h800D;
   localparam logic [15:0] LCAR_OFF_B2_LOW = 16'h800E;
   localparam logic [15:0] LCAR_OFF_B2_HIGH = 16'h800F;
   localparam logic [15:0] LCAR_OFF_B2_LINES = 16'h8010;
   localparam logic [15:0] LCAR_OFF_B4_HIGH = 16'h8014;
   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int LCAR_BIT_DUAL = 3;
   localparam int LCAR_BIT_DISP = 0;
   localparam int LCAR_POS_L3 = 6;
   localparam int LCAR_POS_L2 = 4;
   localparam int LCAR_POS_L1 = 2;
   localparam int LCAR_POS_CUR = 0;
   localparam logic [7:0] LCAR_RST_BYTE = 8'h00;
   localparam logic [15:0] LCAR_RST_ADDR = 16'h0000;
   // ************************************************************
   // Attribute codes.
   // ************************************************************
   localparam logic [1:0] LCAR_ATTR_BLANK = 2'h0;
   localparam logic [1:0] LCAR_ATTR_STEADY = 2'h1;
   localparam logic [1:0] LCAR_ATTR_SLOW = 2'h2;
   localparam logic [1:0] LCAR_ATTR_FAST = 2'h3;
   // ************************************************************
   // Flash timing in frames; the cursor is lit 70 of each 100 percent.
   // ************************************************************
   localparam logic [6:0] LCAR_DIV_SLOW = 7'd32;
   localparam logic [6:0] LCAR_DIV_FAST = 7'd4;
   localparam logic [6:0] LCAR_DIV_CUR_SLOW = 7'd64;
   localparam int LCAR_DUTY_ON_PCT = 70;
   localparam int LCAR_DUTY_TOTAL_PCT = 100;
   localparam logic [15:0] LCAR_RST_CURSOR = 16'h0000;
   // Indirect command states.
   typedef enum logic [2:0] {
      LCAR_IDLE = 3'b001,
      LCAR_SCROLL = 3'b010,
      LCAR_DONE = 3'b100
   } lcar_cmd_e;
endpackage

/* File: rtl/lcar_flash_if.sv */
// Interface carrying frame position between the timing and decode modules.
`timescale 1ns/1ns
interface lcar_flash_if;
   logic [5:0] frame_phase;
   logic frame_tick;
   modport source (output frame_phase, output frame_tick);
   modport sink (input frame_phase, input frame_tick);
endinterface

/* File: rtl/lcar_frame_ctr.sv */
// Free-running frame counter that all flash timing derives from.
`timescale 1ns/1ns
module lcar_frame_ctr
   import lcar_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Frame strobe from the display timing engine.
   input wire logic i_frame_start,
   // Frame position.
   lcar_flash_if.source flash
);
   logic [5:0] phase;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         phase <= 6'h00;
      end else if (i_frame_start) begin
         phase <= phase + 6'h01; // [R16]
      end
   end
   assign flash.frame_phase = phase;
   assign flash.frame_tick = i_frame_start;
endmodule // lcar_frame_ctr

/* File: rtl/lcar_attr_decode.sv */
// Decodes one two-bit layer or cursor attribute field into a visible level.
`timescale 1ns/1ns
module lcar_attr_decode
   import lcar_pkg::*;
(
   // Field and mode.
   input wire logic [1:0] i_attr,
   input wire logic i_is_cursor,
   input wire logic i_disp_en,
   // Frame position.
   lcar_flash_if.sink flash,
   // Result.
   output logic o_visible
);
   logic [5:0] ph;
   logic slow_on;
   logic fast_on;
   logic cur_fast_on;
   logic cur_slow_on;
   logic flash_on;
   assign ph = flash.frame_phase;
   // Layers flash with an even duty; the cursor stays lit for 70 percent.
   assign slow_on = ~ph[4];
   assign fast_on = ~ph[1];
   // Products are sized so that a full phase times one hundred cannot wrap.
   assign cur_slow_on = (12'(ph[4:0]) * 12'(LCAR_DUTY_TOTAL_PCT)) <
                        (12'(LCAR_DIV_SLOW) * 12'(LCAR_DUTY_ON_PCT)); // [R5]
   assign cur_fast_on = (13'(ph) * 13'(LCAR_DUTY_TOTAL_PCT)) <
                        (13'(LCAR_DIV_CUR_SLOW) * 13'(LCAR_DUTY_ON_PCT)); // [R5]
   assign flash_on = (i_attr == LCAR_ATTR_SLOW) ? (i_is_cursor ? cur_slow_on : slow_on) :
                     (i_is_cursor ? cur_fast_on : fast_on); // [R1] [R3] [R4] [R14]
   assign o_visible = i_disp_en && (i_attr != LCAR_ATTR_BLANK) &&
                      ((i_attr == LCAR_ATTR_STEADY) || flash_on); // [R15]
endmodule // lcar_attr_decode

/* File: rtl/lcar_regs.sv */
// Layer attribute, cursor and screen-block scroll register bank.
//
// Contract
// [R1] Second-layer field: blank, steady, flash frame/32, flash frame/4.
// [R2] Dual-panel mode applies the second-layer field to screen block four.
// [R3] First-layer field uses the same four attribute codes.
// [R4] Cursor field: hidden, steady, flash frame/32, flash frame/64.
// [R5] A flashing cursor is visible 70 percent, hidden 30 percent.
// [R6] Memory write with cursor disabled re-enables it and advances position.
// [R7] Memory read advances cursor position but keeps a disabled cursor disabled.
// [R8] Scroll command parameters load registers 0Bh through 14h in order.
// [R9] Block one start address: low 800Bh, high 800Ch, reset zero.
// [R10] Low byte held pending; start address updates on high byte write.
// [R11] Block two start address: low 800Eh, high 800Fh, same commit.
// [R12] Block one size register holds height in lines minus one.
// [R13] Block two size register holds height in lines minus one.
// [R14] Third-layer field in top two bits uses the same codes.
// [R15] Display enable cleared blanks cursor and all layers.
// [R16] All flash timing comes from a free-running frame counter.
`timescale 1ns/1ns
module lcar_regs
   import lcar_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Direct register access.
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Indirect command access.
   input wire logic i_scroll_cmd,
   input wire logic i_param_wr,
   input wire logic [7:0] i_param_data,
   // Display memory access and timing.
   input wire logic i_mem_wr,
   input wire logic i_mem_rd,
   input wire logic i_frame_start,
   // Decoded display state.
   output logic [15:0] o_block1_start,
   output logic [15:0] o_block2_start,
   output logic [7:0] o_block1_lines,
   output logic [7:0] o_block2_lines,
   output logic [15:0] o_cursor_addr,
   output logic o_cursor_enabled,
   output logic [3:0] o_block_visible,
   output logic o_cursor_visible
);
   // ************************************************************
   // Register storage.
   // ************************************************************
   logic [7:0] config_reg;
   logic [7:0] disp_en_reg;
   logic [7:0] attr;
   logic [7:0] b1_low;
   logic [7:0] b2_low;
   logic [15:0] b1_start;
   logic [15:0] b2_start;
   logic [7:0] b1_lines;
   logic [7:0] b2_lines;
   logic [7:0] far_regs [0:3];
   logic [15:0] cursor_addr;
   logic cursor_en;
   logic [7:0] rdata;
   lcar_cmd_e state;
   lcar_cmd_e next_state;
   logic [4:0] param_idx;
   // ************************************************************
   // Write source selection.
   // ************************************************************
   logic ind_wr;
   logic any_wr;
   logic [15:0] wr_addr;
   logic [7:0] wr_data;
   logic [4:0] next_param_idx;
   assign ind_wr = (state == LCAR_SCROLL) && i_param_wr; // [R8]
   assign any_wr = i_reg_wr || ind_wr;
   assign wr_addr = ind_wr ? (LCAR_OFF_B1_LOW + {11'h000, param_idx}) : i_reg_addr; // [R8]
   assign wr_data = ind_wr ? i_param_data : i_reg_wdata;
   assign next_param_idx = param_idx + 5'h01;
   logic wr_cfg;
   logic wr_disp;
   logic wr_attr;
   logic wr_b1l;
   logic wr_b1h;
   logic wr_b1n;
   logic wr_b2l;
   logic wr_b2h;
   logic wr_b2n;
   logic wr_far;
   assign wr_cfg = any_wr && (wr_addr == LCAR_OFF_CONFIG);
   assign wr_disp = any_wr && (wr_addr == LCAR_OFF_DISP_ENABLE);
   assign wr_attr = any_wr && (wr_addr == LCAR_OFF_ATTR);
   assign wr_b1l = any_wr && (wr_addr == LCAR_OFF_B1_LOW);
   assign wr_b1h = any_wr && (wr_addr == LCAR_OFF_B1_HIGH);
   assign wr_b1n = any_wr && (wr_addr == LCAR_OFF_B1_LINES);
   assign wr_b2l = any_wr && (wr_addr == LCAR_OFF_B2_LOW);
   assign wr_b2h = any_wr && (wr_addr == LCAR_OFF_B2_HIGH);
   assign wr_b2n = any_wr && (wr_addr == LCAR_OFF_B2_LINES);
   assign wr_far = any_wr && (wr_addr > LCAR_OFF_B2_LINES) && (wr_addr <= LCAR_OFF_B4_HIGH);
   // ************************************************************
   // Indirect scroll command sequencing.
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         LCAR_IDLE: begin
            if (i_scroll_cmd) begin
               next_state = LCAR_SCROLL;
            end
         end
         LCAR_SCROLL: begin
            if (i_scroll_cmd) begin
               next_state = LCAR_SCROLL;
            end else if (ind_wr && (wr_addr == LCAR_OFF_B4_HIGH)) begin
               next_state = LCAR_DONE; // [R8]
            end
         end
         LCAR_DONE: begin
            next_state = i_scroll_cmd ? LCAR_SCROLL : LCAR_IDLE;
         end
         default: begin
            next_state = LCAR_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state <= LCAR_IDLE;
         param_idx <= 5'h00;
      end else begin
         state <= next_state;
         if (i_scroll_cmd) begin
            param_idx <= 5'h00;
         end else if (ind_wr) begin
            param_idx <= next_param_idx; // [R8]
         end
      end
   end
   // ************************************************************
   // Register writes.
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         config_reg <= LCAR_RST_BYTE;
         disp_en_reg <= LCAR_RST_BYTE;
         attr <= LCAR_RST_BYTE;
         b1_low <= LCAR_RST_BYTE;
         b2_low <= LCAR_RST_BYTE;
         b1_start <= LCAR_RST_ADDR; // [R9]
         b2_start <= LCAR_RST_ADDR; // [R11]
         b1_lines <= LCAR_RST_BYTE;
         b2_lines <= LCAR_RST_BYTE;
      end else begin
         if (wr_cfg) config_reg <= wr_data;
         if (wr_disp) disp_en_reg <= {7'h00, wr_data[LCAR_BIT_DISP]};
         if (wr_attr) attr <= wr_data;
         if (wr_b1l) b1_low <= wr_data; // [R10]
         if (wr_b1h) b1_start <= {wr_data, b1_low}; // [R9] [R10]
         if (wr_b2l) b2_low <= wr_data; // [R11]
         if (wr_b2h) b2_start <= {wr_data, b2_low}; // [R11]
         if (wr_b1n) b1_lines <= wr_data; // [R12]
         if (wr_b2n) b2_lines <= wr_data; // [R13]
      end
   end
   // Blocks three and four are kept only so the scroll sequence reads back.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_far
         always_ff @(posedge i_mclk) begin
            if (!i_resetn) begin
               far_regs[gi] <= LCAR_RST_BYTE;
            end else if (wr_far && (wr_addr[2:0] == 3'(gi + 1))) begin
               far_regs[gi] <= wr_data;
            end
         end
      end
   endgenerate
   // ************************************************************
   // Cursor position tracking.
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         cursor_addr <= LCAR_RST_CURSOR;
         cursor_en <= 1'b1;
      end else begin
         if (i_mem_wr || i_mem_rd) begin
            cursor_addr <= cursor_addr + 16'h0001; // [R6] [R7]
         end
         if (i_mem_wr) begin
            cursor_en <= 1'b1; // [R6]
         end else if (wr_attr && (wr_data[1:0] == LCAR_ATTR_BLANK)) begin
            cursor_en <= 1'b0;
         end else if (wr_attr) begin
            cursor_en <= 1'b1;
         end
      end
   end
   // ************************************************************
   // Read back.
   // ************************************************************
   logic [7:0] rd_mux;
   assign rd_mux = (i_reg_addr == LCAR_OFF_CONFIG) ? config_reg :
                   (i_reg_addr == LCAR_OFF_DISP_ENABLE) ? disp_en_reg :
                   (i_reg_addr == LCAR_OFF_ATTR) ? attr :
                   (i_reg_addr == LCAR_OFF_B1_LOW) ? b1_start[7:0] :
                   (i_reg_addr == LCAR_OFF_B1_HIGH) ? b1_start[15:8] :
                   (i_reg_addr == LCAR_OFF_B1_LINES) ? b1_lines :
                   (i_reg_addr == LCAR_OFF_B2_LOW) ? b2_start[7:0] :
                   (i_reg_addr == LCAR_OFF_B2_HIGH) ? b2_start[15:8] :
                   (i_reg_addr == LCAR_OFF_B2_LINES) ? b2_lines :
                   ((i_reg_addr > LCAR_OFF_B2_LINES) && (i_reg_addr <= LCAR_OFF_B4_HIGH)) ?
                   far_regs[i_reg_addr[1:0] - 2'h1] : 8'h00;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         rdata <= 8'h00;
      end else if (i_reg_rd) begin
         rdata <= rd_mux;
      end
   end
   // ************************************************************
   // Attribute decode.
   // ************************************************************
   lcar_flash_if flash_bus ();
   logic disp_on;
   logic dual;
   logic [1:0] cur_field;
   logic [3:0] vis;
   logic cur_vis;
   assign disp_on = disp_en_reg[LCAR_BIT_DISP];
   assign dual = config_reg[LCAR_BIT_DUAL];
   assign cur_field = cursor_en ? attr[1:0] : LCAR_ATTR_BLANK;
   lcar_frame_ctr u_frame (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_frame_start(i_frame_start),
      .flash(flash_bus.source)
   );
   lcar_attr_decode u_cur (
      .i_attr(cur_field),
      .i_is_cursor(1'b1),
      .i_disp_en(disp_on),
      .flash(flash_bus.sink),
      .o_visible(cur_vis)
   );
   generate
      for (gi = 0; gi < 3; gi++) begin : g_layer
         lcar_attr_decode u_lay (
            .i_attr(attr[2 * gi + 3 -: 2]), // [R1] [R3] [R14]
            .i_is_cursor(1'b0),
            .i_disp_en(disp_on),
            .flash(flash_bus.sink),
            .o_visible(vis[gi])
         );
      end
   endgenerate
   assign vis[3] = dual && vis[1]; // [R2]
   assign o_block_visible = vis;
   assign o_cursor_visible = cur_vis;
   assign o_block1_start = b1_start;
   assign o_block2_start = b2_start;
   assign o_block1_lines = b1_lines;
   assign o_block2_lines = b2_lines;
   assign o_cursor_addr = cursor_addr;
   assign o_cursor_enabled = cursor_en;
   assign o_reg_rdata = rdata;
   // ************************************************************
   // Checks.
   // ************************************************************
   // Either source can commit a high byte, so checks follow the merged write path.
   property p_commit_high;
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_b1h |=> o_block1_start == {$past(wr_data), $past(b1_low)};
   endproperty
   a_commit_high: assert property (p_commit_high) else $error("start high commit wrong"); // [R10]
   property p_b2_commit;
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_b2h |=> o_block2_start == {$past(wr_data), $past(b2_low)};
   endproperty
   a_b2_commit: assert property (p_b2_commit) else $error("block two commit wrong"); // [R11]
   property p_b1_lines;
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_b1n |=> o_block1_lines == $past(wr_data);
   endproperty
   a_b1_lines: assert property (p_b1_lines) else $error("block one size not taken"); // [R12]
   property p_low_pending;
      @(posedge i_mclk) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == LCAR_OFF_B1_LOW && !i_param_wr) |=> $stable(o_block1_start);
   endproperty
   a_low_pending: assert property (p_low_pending) else $error("low byte changed start"); // [R10]
   property p_b2_low_pending;
      @(posedge i_mclk) disable iff (!i_resetn)
      (i_reg_wr && i_reg_addr == LCAR_OFF_B2_LOW && !i_param_wr) |=> $stable(o_block2_start);
   endproperty
   a_b2_low_pending: assert property (p_b2_low_pending) else $error("low byte changed b2"); // [R11]
   property p_disp_off;
      @(posedge i_mclk) disable iff (!i_resetn)
      !disp_on |-> (o_block_visible == 4'h0) && !o_cursor_visible;
   endproperty
   a_disp_off: assert property (p_disp_off) else $error("visible while display off"); // [R15]
   property p_dual_share;
      @(posedge i_mclk) disable iff (!i_resetn)
      o_block_visible[3] == (dual && o_block_visible[1]);
   endproperty
   a_dual_share: assert property (p_dual_share) else $error("block four not tracking two"); // [R2]
   property p_wr_enables;
      @(posedge i_mclk) disable iff (!i_resetn)
      i_mem_wr |=> o_cursor_enabled && (o_cursor_addr == $past(o_cursor_addr) + 16'h0001);
   endproperty
   a_wr_enables: assert property (p_wr_enables) else $error("memory write cursor fault"); // [R6]
   property p_rd_keeps;
      @(posedge i_mclk) disable iff (!i_resetn)
      (i_mem_rd && !i_mem_wr && !o_cursor_enabled && !wr_attr) |=>
      !o_cursor_enabled && (o_cursor_addr == $past(o_cursor_addr) + 16'h0001);
   endproperty
   a_rd_keeps: assert property (p_rd_keeps) else $error("memory read cursor fault"); // [R7]
   // The host may pause between parameters, so each step is keyed to the armed state.
   sequence s_scroll_start;
      i_scroll_cmd;
   endsequence
   sequence s_first_param;
      (state == LCAR_SCROLL) && (param_idx == 5'h00) && i_param_wr && !i_scroll_cmd;
   endsequence
   sequence s_last_param;
      (state == LCAR_SCROLL) && (param_idx == 5'(LCAR_OFF_B4_HIGH - LCAR_OFF_B1_LOW)) &&
      i_param_wr && !i_scroll_cmd;
   endsequence
   property p_scroll_arm;
      @(posedge i_mclk) disable iff (!i_resetn)
      s_scroll_start |=> (state == LCAR_SCROLL) && (param_idx == 5'h00);
   endproperty
   a_scroll_arm: assert property (p_scroll_arm) else $error("scroll not armed"); // [R8]
   property p_scroll_first;
      @(posedge i_mclk) disable iff (!i_resetn)
      s_first_param |=> (b1_low == $past(i_param_data)) &&
      (o_block1_start == $past(o_block1_start));
   endproperty
   a_scroll_first: assert property (p_scroll_first) else $error("scroll order wrong"); // [R8]
   property p_scroll_end;
      @(posedge i_mclk) disable iff (!i_resetn)
      s_last_param |=> (state == LCAR_DONE);
   endproperty
   a_scroll_end: assert property (p_scroll_end) else $error("scroll did not end"); // [R8]
   property p_steady_layer;
      @(posedge i_mclk) disable iff (!i_resetn)
      (disp_on && attr[3:2] == LCAR_ATTR_STEADY) |-> o_block_visible[0];
   endproperty
   a_steady_layer: assert property (p_steady_layer) else $error("steady layer hidden"); // [R3]
endmodule // lcar_regs

/* File: dv/lcar_host_model.sv */
// Host CPU model driving direct register, indirect command and memory cycles.
`timescale 1ns/1ns
module lcar_host_model
   import lcar_pkg::*;
(
   // Clock.
   input wire logic i_mclk,
   // Register and command requests.
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [15:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   input wire logic [7:0] i_reg_rdata,
   output logic o_scroll_cmd,
   output logic o_param_wr,
   output logic [7:0] o_param_data,
   // Display memory requests.
   output logic o_mem_wr,
   output logic o_mem_rd
);
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 16'h0000;
      o_reg_wdata = 8'h00;
      o_scroll_cmd = 1'b0;
      o_param_wr = 1'b0;
      o_param_data = 8'h00;
      o_mem_wr = 1'b0;
      o_mem_rd = 1'b0;
   end
   // Released buses carry the inverse value, so stale data is never taken for fresh.
   task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
      @(negedge i_mclk);
      o_reg_addr = addr;
      o_reg_wdata = data;
      o_reg_wr = 1'b1;
      @(negedge i_mclk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~addr;
      o_reg_wdata = ~data;
   endtask
   task automatic reg_read(input logic [15:0] addr, output logic [7:0] data);
      @(negedge i_mclk);
      o_reg_addr = addr;
      o_reg_rd = 1'b1;
      @(negedge i_mclk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~addr;
      @(negedge i_mclk);
      data = i_reg_rdata;
   endtask
   task automatic set_start(input logic [15:0] low_addr, input logic [15:0] value);
      reg_write(low_addr, value[7:0]);
      reg_write(low_addr + 16'h0001, value[15:8]);
   endtask
   task automatic scroll_start();
      @(negedge i_mclk);
      o_scroll_cmd = 1'b1;
      @(negedge i_mclk);
      o_scroll_cmd = 1'b0;
   endtask
   task automatic param(input logic [7:0] data);
      @(negedge i_mclk);
      o_param_data = data;
      o_param_wr = 1'b1;
      @(negedge i_mclk);
      o_param_wr = 1'b0;
      o_param_data = ~data;
   endtask
   task automatic mem(input logic is_write);
      @(negedge i_mclk);
      o_mem_wr = is_write;
      o_mem_rd = ~is_write;
      @(negedge i_mclk);
      o_mem_wr = 1'b0;
      o_mem_rd = 1'b0;
   endtask
endmodule // lcar_host_model

/* File: dv/lcd_layer_attr_scroll_regs_tb.sv */
// Self-checking testbench for the layer attribute and scroll register bank.
`timescale 1ns/1ns
module lcd_layer_attr_scroll_regs_tb;
   import lcar_pkg::*;
   logic mclk;
   logic resetn;
   logic frame_start;
   logic reg_wr, reg_rd, scroll_cmd, param_wr, mem_wr, mem_rd;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, param_data;
   logic [15:0] b1_start, b2_start, cur_addr;
   logic [7:0] b1_lines, b2_lines;
   logic cur_en, cur_vis;
   logic [3:0] blk_vis;
   logic [5:0] phase;
   logic [15:0] exp_cur;
   int err_count;
   int n_tests;
   lcar_host_model lcar_host_model_inst (.i_mclk(mclk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
      .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata),
      .o_scroll_cmd(scroll_cmd), .o_param_wr(param_wr), .o_param_data(param_data),
      .o_mem_wr(mem_wr), .o_mem_rd(mem_rd));
   lcar_regs lcar_regs_inst (.i_mclk(mclk), .i_resetn(resetn), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
      .i_scroll_cmd(scroll_cmd), .i_param_wr(param_wr), .i_param_data(param_data),
      .i_mem_wr(mem_wr), .i_mem_rd(mem_rd), .i_frame_start(frame_start),
      .o_block1_start(b1_start), .o_block2_start(b2_start), .o_block1_lines(b1_lines),
      .o_block2_lines(b2_lines), .o_cursor_addr(cur_addr), .o_cursor_enabled(cur_en),
      .o_block_visible(blk_vis), .o_cursor_visible(cur_vis));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ************************************************************
   // Shared helpers.
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      lcar_host_model_inst.reg_read(addr, d);
      check({24'h000000, d}, {24'h000000, exp});
   endtask
   task automatic frame();
      @(negedge mclk);
      frame_start = 1'b1;
      @(negedge mclk);
      frame_start = 1'b0;
      phase = phase + 6'h01;
   endtask
   function automatic logic lay(input logic [1:0] c);
      return (c == 2'h1) || (c == 2'h2 && !phase[4]) || (c == 2'h3 && !phase[1]);
   endfunction
   // The lit share is rounded to whole frames: 23 of 32 and 45 of 64.
   function automatic logic curv(input logic [1:0] c);
      return (c == 2'h1) || (c == 2'h2 && phase[4:0] < 5'h17) || (c == 2'h3 && phase < 6'h2D);
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_reset();
      for (int a = 16'h800B; a <= 16'h8010; a++) begin
         rd_chk(16'(a), 8'h00);
      end
      lcar_host_model_inst.reg_write(16'h8030, 8'h5A);
      rd_chk(16'h8030, 8'h00);
      check({cur_en, blk_vis, cur_vis}, 6'h20);
      $display("reset test done");
   endtask
   task automatic t_commit();
      lcar_host_model_inst.reg_write(16'h800B, 8'h34);
      check(b1_start, 16'h0000);
      rd_chk(16'h800B, 8'h00);
      lcar_host_model_inst.reg_write(16'h800C, 8'h12);
      check(b1_start, 16'h1234);
      rd_chk(16'h800B, 8'h34);
      lcar_host_model_inst.set_start(16'h800E, 16'h5678);
      check(b2_start, 16'h5678);
      rd_chk(16'h800F, 8'h56);
      lcar_host_model_inst.reg_write(16'h800B, 8'hAB);
      check(b1_start, 16'h1234);
      lcar_host_model_inst.reg_write(16'h800C, 8'hCD);
      check(b1_start, 16'hCDAB);
      lcar_host_model_inst.reg_write(16'h800D, 8'hFF);
      lcar_host_model_inst.reg_write(16'h8010, 8'h01);
      check({b1_lines, b2_lines}, 16'hFF01);
      $display("commit test done");
   endtask
   task automatic t_scroll();
      lcar_host_model_inst.param(8'h5A);
      check(b1_lines, 8'hFF);
      lcar_host_model_inst.scroll_start();
      for (int i = 0; i < 10; i++) begin
         lcar_host_model_inst.param(8'(8'h11 * (i + 1)));
      end
      lcar_host_model_inst.param(8'hEE);
      check({b1_start, b1_lines}, 24'h221133);
      check({b2_start, b2_lines}, 24'h554466);
      rd_chk(16'h8011, 8'h77);
      rd_chk(16'h8014, 8'hAA);
      $display("scroll test done");
   endtask
   task automatic t_flash();
      logic [1:0] c;
      lcar_host_model_inst.reg_write(16'h8000, 8'h08);
      lcar_host_model_inst.reg_write(16'h8009, 8'h01);
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         lcar_host_model_inst.reg_write(16'h800A, {c, c + 2'h1, c + 2'h2, c + 2'h3});
         for (int f = 0; f < 64; f++) begin
            check(blk_vis[0], lay(c + 2'h2));
            check(blk_vis[1], lay(c + 2'h1));
            check(blk_vis[3], lay(c + 2'h1));
            check(blk_vis[2], lay(c));
            check(cur_vis, curv(c + 2'h3));
            frame();
         end
      end
      lcar_host_model_inst.reg_write(16'h800A, 8'h55);
      lcar_host_model_inst.reg_write(16'h8000, 8'h00);
      check({blk_vis, cur_vis}, 5'h0F);
      lcar_host_model_inst.reg_write(16'h8009, 8'h00);
      check({blk_vis, cur_vis}, 5'h00);
      $display("flash test done");
   endtask
   task automatic t_cursor();
      lcar_host_model_inst.reg_write(16'h800A, 8'h00);
      check(cur_en, 1'b0);
      lcar_host_model_inst.mem(1'b0);
      exp_cur = exp_cur + 16'h0001;
      check({cur_en, cur_addr}, {1'b0, exp_cur});
      lcar_host_model_inst.mem(1'b1);
      exp_cur = exp_cur + 16'h0001;
      check({cur_en, cur_addr}, {1'b1, exp_cur});
      lcar_host_model_inst.mem(1'b0);
      exp_cur = exp_cur + 16'h0001;
      check({cur_en, cur_addr}, {1'b1, exp_cur});
      $display("cursor test done");
   endtask
   initial begin
      err_count = 0;
      n_tests = 0;
      phase = 6'h00;
      exp_cur = 16'h0000;
      resetn = 1'b0;
      frame_start = 1'b0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      t_reset();
      t_commit();
      t_scroll();
      t_flash();
      t_cursor();
      final_report();
   end
   // The longest path is about 630 cycles, so this span leaves wide margin.
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      final_report();
   end
endmodule // lcd_layer_attr_scroll_regs_tb
